// *** inc/usp_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the upstream port status logic
`ifndef USP_CFG_SVH
`define USP_CFG_SVH

// Configuration space byte offsets
`define USP_COMMAND_OFFSET 12'h004
`define USP_STATUS_OFFSET 12'h006
// Dword index holding command (low half) and status (high half)
`define USP_CMDSTS_DWORD 10'h001

// Status register field positions
`define USP_POISONED_RX_BIT 15
`define USP_ERROR_MSG_SENT_BIT 14
`define USP_UNSUPPORTED_CPL_BIT 13
`define USP_ABORT_CPL_RX_BIT 12
`define USP_ABORT_CPL_SENT_BIT 11
`define USP_SELECT_TIMING_HI 10
`define USP_SELECT_TIMING_LO 9
`define USP_MASTER_POISON_BIT 8
`define USP_BACK_TO_BACK_CAP_BIT 7
`define USP_STATUS_RSVD6_BIT 6
`define USP_HIGH_FREQ_CAP_BIT 5
`define USP_CAP_CHAIN_PRESENT_BIT 4
`define USP_INT_PENDING_BIT 3
`define USP_STATUS_RSVD_LO_HI 2
`define USP_STATUS_RSVD_LO_LO 0

// Command register field positions
`define USP_ERROR_MSG_ENABLE_BIT 8
`define USP_POISON_REPORT_ENABLE_BIT 6

// Reset values
`define USP_STATUS_RESET 16'h0010
`define USP_COMMAND_RESET 16'h0000

// Read answer latency in core clock cycles
`define USP_READ_LATENCY 1

`endif

// *** inc/usp_pkg.sv ***
// Types shared by the upstream port status logic
package usp_pkg;

   // Number of event flags held in the status register
   localparam int USP_NUM_FLAGS = 6;

   // Events reported by the upstream port datapath, one-cycle pulses
   typedef struct packed {
      logic poisoned_tlp_rx;
      logic error_msg_sent;
      logic unsupported_cpl_rx;
      logic abort_cpl_rx;
      logic abort_cpl_sent;
      logic poisoned_cpl_rx;
      logic poisoned_wr_sent;
   } usp_events_t;

   // Configuration space access request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } usp_cfg_req_t;

   // INTx virtual wire message
   typedef enum logic [1:0] {
      USP_INTA = 2'h0,
      USP_INTB = 2'h1,
      USP_INTC = 2'h2,
      USP_INTD = 2'h3
   } usp_intx_line_t;

   typedef struct packed {
      logic assert_msg;
      usp_intx_line_t line;
   } usp_intx_t;

endpackage

// *** src/usp_flag_cell.sv ***
// One hardware-set, write-one-to-clear status flag
module usp_flag_cell (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic set_pulse,
   input wire logic clr_pulse,
   output logic flag_q
);

   logic flag_d;

   // Set beats a clear in the same cycle
   assign flag_d = set_pulse | (flag_q & ~clr_pulse);

   // Flag storage, cleared by port reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

endmodule

// *** src/usp_status_regs.sv ***
// Upstream port command enables, status flags, config read/write port and INTx relay
`include "usp_cfg.svh"

// Functional notes
// - Poisoned TLP received on upstream port sets flag bit 15.
// - Bit 15 sets regardless of the poison-report enable.
// - Bit 14 sets when a fatal/nonfatal error message goes upstream while enabled.
// - Bit 13 sets on received completion with Unsupported Request status.
// - Bit 12 sets on received completion with Completer Abort status.
// - Bit 11 sets when the port answers a request with Completer Abort.
// - Bit 8 sets on poisoned completion received or poisoned write sent.
// - Bit 8 never sets while the poison-report enable is zero.
// - Select-timing field bits 10:9 read zero, writes ignored.
// - Back-to-back bit 7 and high-frequency bit 5 read zero.
// - Reserved bit 6 reads zero.
// - Reserved bits 2:0 read zero.
// - Capability-chain bit 4 always reads one.
// - Interrupt-pending bit 3 reads zero; port raises no own interrupt.
// - INTx messages from downstream ports are relayed out the upstream port.
// - Software clears a flag by writing one; writing zero leaves it.
// - Poison-report enable is command bit 6, gating the master-poison flag.
// - Error-message enable is command bit 8, allowing error messages upstream.
module usp_status_regs
   import usp_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire usp_cfg_req_t CFG_REQ,
   output logic [31:0] CFG_RDATA,
   output logic CFG_RVALID,
   input wire usp_events_t EVENTS,
   output logic ERROR_MSG_ALLOW,
   output logic POISON_REPORT_EN,
   output logic [15:0] STATUS,
   input wire logic DSP_INTX_VALID,
   input wire usp_intx_t DSP_INTX,
   output logic DSP_INTX_READY,
   output logic USP_INTX_VALID,
   output usp_intx_t USP_INTX,
   input wire logic USP_INTX_READY
);

   // Reset synchroniser
   logic rst_meta_q;
   logic rst_sync_q;

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // Access decode for the command/status dword
   wire dword_hit = (CFG_REQ.addr[11:2] == `USP_CMDSTS_DWORD);
   wire wr_hit = CFG_REQ.wr & dword_hit;
   wire rd_req = CFG_REQ.rd;
   wire wr_cmd_lo = wr_hit & CFG_REQ.be[0];
   wire wr_cmd_hi = wr_hit & CFG_REQ.be[1];
   wire [15:0] status_wdata = CFG_REQ.wdata[31:16];
   wire [15:0] status_lane_mask = {{8{CFG_REQ.be[3]}}, {8{CFG_REQ.be[2]}}};
   // Only event flag positions take a clear; fixed fields ignore writes
   localparam logic [15:0] status_w1c_mask = (16'h0001 << `USP_POISONED_RX_BIT)
      | (16'h0001 << `USP_ERROR_MSG_SENT_BIT)
      | (16'h0001 << `USP_UNSUPPORTED_CPL_BIT)
      | (16'h0001 << `USP_ABORT_CPL_RX_BIT)
      | (16'h0001 << `USP_ABORT_CPL_SENT_BIT)
      | (16'h0001 << `USP_MASTER_POISON_BIT);
   wire [15:0] status_w1c = wr_hit ? (status_wdata & status_lane_mask & status_w1c_mask) : 16'h0000;

   // Reset images of both registers, bit-selected where needed
   localparam logic [15:0] cmd_reset_val = `USP_COMMAND_RESET;
   localparam logic [15:0] status_reset_val = `USP_STATUS_RESET;

   // Command enables
   logic poison_report_enable_q;
   logic error_msg_enable_q;

   always_ff @(posedge CORE_CLK or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         poison_report_enable_q <= cmd_reset_val[`USP_POISON_REPORT_ENABLE_BIT];
         error_msg_enable_q <= cmd_reset_val[`USP_ERROR_MSG_ENABLE_BIT];
      end else begin
         if (wr_cmd_lo) begin
            poison_report_enable_q <= CFG_REQ.wdata[`USP_POISON_REPORT_ENABLE_BIT];
         end
         if (wr_cmd_hi) begin
            error_msg_enable_q <= CFG_REQ.wdata[`USP_ERROR_MSG_ENABLE_BIT];
         end
      end
   end

   assign POISON_REPORT_EN = poison_report_enable_q;
   assign ERROR_MSG_ALLOW = error_msg_enable_q;

   // Flag cell index of each event flag
   localparam int idx_poisoned_rx = 5;
   localparam int idx_error_msg_sent = 4;
   localparam int idx_unsupported_cpl = 3;
   localparam int idx_abort_cpl_rx = 2;
   localparam int idx_abort_cpl_sent = 1;
   localparam int idx_master_poison = 0;

   // Event qualification against the command enables
   wire poisoned_tlp_seen = EVENTS.poisoned_tlp_rx;
   wire error_msg_counted = EVENTS.error_msg_sent & error_msg_enable_q;
   wire unsupported_cpl_seen = EVENTS.unsupported_cpl_rx;
   wire abort_cpl_rx_seen = EVENTS.abort_cpl_rx;
   wire abort_cpl_sent_seen = EVENTS.abort_cpl_sent;
   wire master_poison_event = EVENTS.poisoned_cpl_rx | EVENTS.poisoned_wr_sent;
   wire master_poison_counted = master_poison_event & poison_report_enable_q;

   // Hardware set sources for each flag
   logic [USP_NUM_FLAGS-1:0] flag_set;
   logic [USP_NUM_FLAGS-1:0] flag_clr;
   logic [USP_NUM_FLAGS-1:0] flag_q;

   assign flag_set[idx_poisoned_rx] = poisoned_tlp_seen;
   assign flag_set[idx_error_msg_sent] = error_msg_counted;
   assign flag_set[idx_unsupported_cpl] = unsupported_cpl_seen;
   assign flag_set[idx_abort_cpl_rx] = abort_cpl_rx_seen;
   assign flag_set[idx_abort_cpl_sent] = abort_cpl_sent_seen;
   assign flag_set[idx_master_poison] = master_poison_counted;

   // Write-one-to-clear strobes, per flag position
   assign flag_clr[idx_poisoned_rx] = status_w1c[`USP_POISONED_RX_BIT];
   assign flag_clr[idx_error_msg_sent] = status_w1c[`USP_ERROR_MSG_SENT_BIT];
   assign flag_clr[idx_unsupported_cpl] = status_w1c[`USP_UNSUPPORTED_CPL_BIT];
   assign flag_clr[idx_abort_cpl_rx] = status_w1c[`USP_ABORT_CPL_RX_BIT];
   assign flag_clr[idx_abort_cpl_sent] = status_w1c[`USP_ABORT_CPL_SENT_BIT];
   assign flag_clr[idx_master_poison] = status_w1c[`USP_MASTER_POISON_BIT];

   // One flag cell per event flag
   genvar gi;
   generate
      for (gi = 0; gi < USP_NUM_FLAGS; gi++) begin : g_flag
         usp_flag_cell u_cell (
            .clk(CORE_CLK),
            .rst_n(rst_sync_q),
            .set_pulse(flag_set[gi]),
            .clr_pulse(flag_clr[gi]),
            .flag_q(flag_q[gi])
         );
      end
   endgenerate

   // Named views of the flag cells
   wire poisoned_rx_flag = flag_q[idx_poisoned_rx];
   wire error_msg_sent_flag = flag_q[idx_error_msg_sent];
   wire unsupported_cpl_flag = flag_q[idx_unsupported_cpl];
   wire abort_cpl_rx_flag = flag_q[idx_abort_cpl_rx];
   wire abort_cpl_sent_flag = flag_q[idx_abort_cpl_sent];
   wire master_poison_flag = flag_q[idx_master_poison];

   // Fixed fields of the status image, never written
   wire [1:0] select_timing = 2'h0;
   wire back_to_back_cap = 1'h0;
   wire high_freq_cap = 1'h0;
   wire status_rsvd6 = 1'h0;
   wire [2:0] status_rsvd_lo = 3'h0;
   wire cap_chain_present = status_reset_val[`USP_CAP_CHAIN_PRESENT_BIT];
   wire int_pending = 1'h0;

   // Status image, flags from the cells and fixed fields
   logic [15:0] status_image;

   always_comb begin
      status_image = 16'h0000;
      status_image[`USP_POISONED_RX_BIT] = poisoned_rx_flag;
      status_image[`USP_ERROR_MSG_SENT_BIT] = error_msg_sent_flag;
      status_image[`USP_UNSUPPORTED_CPL_BIT] = unsupported_cpl_flag;
      status_image[`USP_ABORT_CPL_RX_BIT] = abort_cpl_rx_flag;
      status_image[`USP_ABORT_CPL_SENT_BIT] = abort_cpl_sent_flag;
      status_image[`USP_SELECT_TIMING_HI:`USP_SELECT_TIMING_LO] = select_timing;
      status_image[`USP_MASTER_POISON_BIT] = master_poison_flag;
      status_image[`USP_BACK_TO_BACK_CAP_BIT] = back_to_back_cap;
      status_image[`USP_STATUS_RSVD6_BIT] = status_rsvd6;
      status_image[`USP_HIGH_FREQ_CAP_BIT] = high_freq_cap;
      status_image[`USP_CAP_CHAIN_PRESENT_BIT] = cap_chain_present;
      status_image[`USP_INT_PENDING_BIT] = int_pending;
      status_image[`USP_STATUS_RSVD_LO_HI:`USP_STATUS_RSVD_LO_LO] = status_rsvd_lo;
   end

   assign STATUS = status_image;

   // Command image, only the two enables are held
   logic [15:0] command_image;

   always_comb begin
      command_image = 16'h0000;
      command_image[`USP_POISON_REPORT_ENABLE_BIT] = poison_report_enable_q;
      command_image[`USP_ERROR_MSG_ENABLE_BIT] = error_msg_enable_q;
   end

   // Read data, registered; unmapped dwords read zero
   logic [31:0] rdata_q;
   logic rvalid_q;
   wire [31:0] cmdsts_image = {status_image, command_image};
   wire [31:0] rdata_d = dword_hit ? cmdsts_image : 32'h0000_0000;

   always_ff @(posedge CORE_CLK or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         rdata_q <= 32'h0000_0000;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= rd_req;
         if (rd_req) begin
            rdata_q <= rdata_d;
         end
      end
   end

   assign CFG_RDATA = rdata_q;
   assign CFG_RVALID = rvalid_q;

   // INTx relay: single holding stage toward the upstream link
   logic intx_valid_q;
   usp_intx_t intx_q;
   wire intx_take = DSP_INTX_VALID & DSP_INTX_READY;
   wire intx_drain = intx_valid_q & USP_INTX_READY;

   assign DSP_INTX_READY = ~intx_valid_q | USP_INTX_READY;

   always_ff @(posedge CORE_CLK or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         intx_valid_q <= 1'b0;
         intx_q <= '0;
      end else begin
         if (intx_take) begin
            intx_valid_q <= 1'b1;
            intx_q <= DSP_INTX;
         end else if (intx_drain) begin
            intx_valid_q <= 1'b0;
         end
      end
   end

   assign USP_INTX_VALID = intx_valid_q;
   assign USP_INTX = intx_q;

endmodule

// *** verification/usp_link_model.sv ***
// Upstream link partner model accepting relayed INTx messages
module usp_link_model (
   input wire logic clk,
   output logic ready
);
   timeunit 1ns;
   timeprecision 1ps;
   int seed = 7;
   // Accept stalls at random, changed on the falling edge
   initial ready = 1'b0;
   always @(negedge clk) begin
      ready <= ($random(seed) % 3) != 0;
   end
endmodule

// *** verification/usp_status_regs_asserts.sv ***
// Concurrent checks on the upstream port status ports
module usp_status_regs_asserts
   import usp_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire usp_cfg_req_t CFG_REQ,
   input wire logic [31:0] CFG_RDATA,
   input wire logic CFG_RVALID,
   input wire usp_events_t EVENTS,
   input wire logic POISON_REPORT_EN,
   input wire logic ERROR_MSG_ALLOW,
   input wire logic [15:0] STATUS,
   input wire logic USP_INTX_VALID,
   input wire usp_intx_t USP_INTX,
   input wire logic USP_INTX_READY
);
   // Core clock, quiet in reset
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   AST_PRX: assert property (EVENTS.poisoned_tlp_rx |=> STATUS[15]) else $error("bit15 unset");
   AST_EMS: assert property (EVENTS.error_msg_sent && ERROR_MSG_ALLOW |=> STATUS[14]) else $error("bit14");
   AST_URC: assert property (EVENTS.unsupported_cpl_rx |=> STATUS[13]) else $error("bit13 unset");
   AST_CAR: assert property (EVENTS.abort_cpl_rx |=> STATUS[12]) else $error("bit12 unset");
   AST_CAS: assert property (EVENTS.abort_cpl_sent |=> STATUS[11]) else $error("bit11 unset");
   AST_MPS: assert property ((EVENTS.poisoned_cpl_rx || EVENTS.poisoned_wr_sent) && POISON_REPORT_EN |=> STATUS[8])
      else $error("bit8");
   AST_MPG: assert property ($rose(STATUS[8]) |-> $past(POISON_REPORT_EN)) else $error("bit8 ungated");
   AST_FIX: assert property ((STATUS & 16'h06FF) == 16'h0010) else $error("fixed bits");
   AST_CLR: assert property ($fell(STATUS[15]) |-> $past(CFG_REQ.wr)) else $error("bit15 lost");
   AST_RDV: assert property (CFG_REQ.rd && CFG_REQ.addr[11:2] == 10'h001 |=>
      CFG_RVALID && CFG_RDATA[31:16] == $past(STATUS)) else $error("read data");
   AST_IXH: assert property (USP_INTX_VALID && !USP_INTX_READY |=> USP_INTX_VALID && $stable(USP_INTX))
      else $error("intx dropped");
endmodule
bind usp_status_regs usp_status_regs_asserts u_usp_status_regs_asserts (.CORE_CLK, .RESET_N, .CFG_REQ, .CFG_RDATA,
   .CFG_RVALID, .EVENTS, .POISON_REPORT_EN, .ERROR_MSG_ALLOW, .STATUS, .USP_INTX_VALID, .USP_INTX, .USP_INTX_READY);

// *** verification/usp_status_regs_tb.sv ***
// Self-checking bench of the upstream port status logic
module usp_status_regs_tb import usp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   usp_cfg_req_t req = '0;
   usp_events_t evt = '0;
   logic dv = 1'b0;
   usp_intx_t dx = '0;
   logic [31:0] rdata;
   logic rvalid, ema, pre, dr, uv, ur;
   logic [15:0] sts;
   usp_intx_t ux;
   logic [31:0] rq[$];
   usp_intx_t iq[$];
   int errors = 0;
   int comparisons = 0;
   int seed = 41;
   logic [31:0] v;
   initial forever #2 clk = ~clk;
   usp_status_regs u_usp_status_regs (.CORE_CLK(clk), .RESET_N(rst_n), .CFG_REQ(req), .CFG_RDATA(rdata),
      .CFG_RVALID(rvalid), .EVENTS(evt), .ERROR_MSG_ALLOW(ema), .POISON_REPORT_EN(pre), .STATUS(sts),
      .DSP_INTX_VALID(dv), .DSP_INTX(dx), .DSP_INTX_READY(dr), .USP_INTX_VALID(uv), .USP_INTX(ux),
      .USP_INTX_READY(ur));
   usp_link_model u_usp_link_model (.clk(clk), .ready(ur));
   // Compare and count
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic give_verdict();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Config read with its expected answer queued
   task automatic rd(logic [11:0] a, logic [31:0] e);
      @(negedge clk);
      rq.push_back(e);
      req = '{1'b1, 1'b0, a, 4'hF, 32'h0};
      @(negedge clk);
      req.rd = 1'b0;
   endtask
   // Config write to dword 1, event pulse in the same cycle
   task automatic wr(logic [31:0] d, logic [3:0] b, usp_events_t e);
      @(negedge clk);
      req = '{1'b0, 1'b1, 12'h004, b, d};
      evt = e;
      @(negedge clk);
      req.wr = 1'b0;
      evt = '0;
   endtask
   // INTx offer held until taken
   task automatic ix(usp_intx_t x);
      int k;
      @(negedge clk);
      iq.push_back(x);
      dv = 1'b1;
      dx = x;
      k = 0;
      do @(posedge clk); while (dr !== 1'b1 && ++k < 50);
      if (k >= 50) begin
         errors++;
         give_verdict();
      end
      @(negedge clk);
      dv = 1'b0;
   endtask
   // Output watcher against the oldest note
   always @(posedge clk) begin
      if (rvalid === 1'b1) chk("rdata", rdata, rq.pop_front());
      if (uv === 1'b1 && ur === 1'b1) chk("intx", 32'(ux), 32'(iq.pop_front()));
   end
   // Main sequence
   initial begin
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(posedge clk);
      chk("en", {ema, pre}, 2'b00);
      rd(12'h004, 32'h0010_0000);
      rd(12'h008, 32'h0);
      wr(32'h0, 4'h0, 7'h62);
      rd(12'h004, 32'h8010_0000);
      for (int i = 0; i < 4; i++) begin
         v = $random(seed);
         wr(v, 4'h3, '0);
         chk("cmd", {ema, pre}, {v[8], v[6]});
      end
      wr(32'hFFFF_0140, 4'h3, '0);
      for (int i = 0; i < 7; i++) wr(32'h0, 4'h0, 7'h40 >> i);
      rd(12'h004, 32'hF910_0140);
      wr(32'h0, 4'hC, '0);
      rd(12'h004, 32'hF910_0140);
      wr(32'hFFFF_0000, 4'hC, 7'h08);
      chk("sts", sts, 16'h1010);
      wr(32'hFFFF_0000, 4'h4, '0);
      chk("lane", sts, 16'h1010);
      for (int i = 0; i < 6; i++) begin
         v = $random(seed);
         ix(v[2:0]);
      end
      repeat (30) @(negedge clk);
      chk("left", rq.size() + iq.size(), 0);
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(posedge clk);
      rd(12'h004, 32'h0010_0000);
      repeat (3) @(negedge clk);
      give_verdict();
   end
endmodule
